// ### include/spb_cfg.svh
// Constants for the three-wire peripheral bus master: offsets, fields, resets, frame counts
`ifndef SPB_CFG_SVH
`define SPB_CFG_SVH
// Register byte offsets on the APB slave
`define CTRL_OFS 12'h000
`define LOC_OFS 12'h004
`define MULT_OFS 12'h008
`define OFFS_OFS 12'h00c
`define STAT_OFS 12'h010
// Location memory page, PADDR[11:8]
`define MEM_PAGE 4'h1
// Control register field positions
`define F_OP 0
`define F_FUNC 2
`define F_ADDR 4
`define F_CHAN 8
`define F_REPS 12
`define F_GO 31
// Reset values and fixed results
`define MULT_RST 16'h0000
`define OFFS_RST 32'h00000000
`define ERR_VAL 32'hfffe7961
// Stepping limits
`define CHAN_LAST 3'h7
`define AO_LAST 2'h3
`define CD_STEP 6'h10
`define GATHER_LAST 4'hf
// Frame shape on the link: bits sent, total bits, last phase of a bit cell
`define TX_BITS 6'h1b
`define FRAME_BITS 6'h2c
`define CELL_LAST 3'h7
`endif

// ### include/spb_pkg.sv
// Types shared by the peripheral bus master and its link shifter
package spb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PREP = 3'b001, ST_SEND = 3'b010, ST_WAIT = 3'b011, ST_STORE = 3'b100
  } seq_t;
  typedef enum logic [1:0] {
    OP_SWITCH = 2'b00, OP_ANALOG = 2'b01, OP_PORTS = 2'b10, OP_RSVD = 2'b11
  } op_t;
  typedef enum logic [1:0] {
    FN_STATE = 2'b00, FN_DUTY = 2'b01, FN_COUNT = 2'b10, FN_SIGN = 2'b11
  } fn_t;
  typedef enum logic {LK_IDLE = 1'b0, LK_SHIFT = 1'b1} lk_t;
  typedef struct packed {
    seq_t st; op_t op; fn_t func;
    logic [3:0] cfg_addr; logic [3:0] cfg_chan; logic [7:0] cfg_reps; logic [5:0] cfg_loc;
    logic [15:0] mult; logic [31:0] offset;
    logic [3:0] addr; logic [2:0] chan; logic [7:0] left; logic [5:0] loc;
    logic [1:0] sub; logic [3:0] gidx; logic [15:0] payload;
    logic req; logic ack1; logic ack2; logic ack3;
    logic busy; logic noresp; logic done;
    logic pready; logic pslverr; logic [31:0] prdata;
  } sys_t;
  typedef struct packed {
    lk_t st; logic req1; logic req2; logic req3;
    logic din1; logic din2; logic din3; logic dinf;
    logic [5:0] bitpos; logic [2:0] phase; logic [26:0] shreg; logic [16:0] rx;
    logic ack; logic clk_o; logic sel_o; logic oe_n;
  } link_t;
endpackage

// ### rtl/frame_shifter.sv
// Link-clock frame shifter: sends one command frame and collects the module reply
`timescale 1ns/10ps
`include "spb_cfg.svh"
module frame_shifter import spb_pkg::*; (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic req_tog,
  input wire logic [26:0] tx_word,
  output logic ack_tog,
  output logic [16:0] rx_word,
  input wire logic din_i,
  output logic dout,
  output logic dout_oe_n,
  output logic clk_out,
  output logic sel_out
);
  link_t r; // Registered state
  link_t n; // Next state

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = r;
    // Request toggle and data pin pass three flops; first is read only by second
    n.req1 = req_tog;
    n.req2 = r.req1;
    n.req3 = r.req2;
    n.din1 = din_i;
    n.din2 = r.din1;
    n.din3 = r.din2;
    // Data pin counts as changed once stages two and three agree
    if (r.din2 == r.din3) begin
      n.dinf = r.din3;
    end
    case (r.st)
      LK_IDLE: begin
        // New request: raise select and drive the first bit
        if (r.req2 != r.req3) begin
          n.st = LK_SHIFT;
          n.sel_o = 1'b1;
          n.oe_n = 1'b0;
          n.shreg = tx_word;
          n.bitpos = 6'h0;
          n.phase = 3'h0;
        end
      end
      LK_SHIFT: begin
        // Clock low for the first half cell, high for the second
        n.phase = r.phase + 3'h1;
        n.clk_o = n.phase[2];
        if (r.phase == `CELL_LAST) begin
          // Sent bits shift out MSB first; reply bits are caught late in the cell
          if (r.bitpos >= `TX_BITS) begin
            n.rx = {r.rx[15:0], r.dinf};
          end else begin
            n.shreg = {r.shreg[25:0], 1'b0};
          end
          n.bitpos = r.bitpos + 6'h1;
          // Release the data line for the reply bits
          n.oe_n = (r.bitpos >= `TX_BITS - 6'h1);
          if (r.bitpos == `FRAME_BITS - 6'h1) begin
            n.st = LK_IDLE;
            n.sel_o = 1'b0;
            n.oe_n = 1'b1;
            n.clk_o = 1'b0;
            n.ack = ~r.ack;
          end
        end
      end
      default: n.st = LK_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign ack_tog = r.ack;
  assign rx_word = r.rx;
  assign dout = r.shreg[26];
  assign dout_oe_n = r.oe_n;
  assign clk_out = r.clk_o;
  assign sel_out = r.sel_o;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  clk_in_frame_a: assert property (!r.sel_o |-> !r.clk_o)
    else $error("bus clock moved outside a frame");
  reply_release_a: assert property ((r.st == LK_SHIFT && r.bitpos >= `TX_BITS) |-> r.oe_n)
    else $error("data line driven during reply bits");
  frame_ack_a: assert property ($fell(r.sel_o) |-> r.ack != $past(r.ack))
    else $error("frame ended without acknowledge toggle");
endmodule

// ### rtl/seq_bus_master.sv
// Three-wire peripheral bus master with APB registers and a location memory
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "spb_cfg.svh"
module seq_bus_master import spb_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BUS_DATA_LINE_I,
  output logic BUS_DATA_LINE_O,
  output logic BUS_DATA_LINE_OE_N,
  output logic BUS_CLOCK_HANDSHAKE_LINE,
  output logic BUS_SELECT_LINE
);
  sys_t r; // Registered state
  sys_t n; // Next state
  logic [31:0] mem [64]; // Location memory, sources and destinations
  logic mem_we; // Memory write strobe
  logic [5:0] mem_idx; // Memory write index
  logic [31:0] mem_wd; // Memory write data
  logic acc; // APB access phase
  logic in_mem; // Address falls in the location page
  logic wr_fire; // Write takes effect this edge
  logic go_fire; // Accepted start command
  logic [5:0] gaddr; // Source location being gathered
  logic gbit; // Port state of that location
  logic [31:0] raw; // Reply widened per function
  logic signed [47:0] prod; // Reply times multiplier
  logic [31:0] scaled; // Scaled reading
  logic [31:0] value; // Value stored for a switch read
  logic ack_tog; // Frame done toggle from link domain
  logic [16:0] rx_word; // Reply: no-response flag then 16 data bits

  //////////////////////////////////////////////////////////////////////////////
  // Link shifter on its own clock; tx word is held steady while a frame runs
  frame_shifter u_link (
    .link_clk(LINK_CLK),
    .rst_n(RST_N),
    .req_tog(r.req),
    .tx_word({r.addr, r.op, r.func, r.chan, r.payload}),
    .ack_tog(ack_tog),
    .rx_word(rx_word),
    .din_i(BUS_DATA_LINE_I),
    .dout(BUS_DATA_LINE_O),
    .dout_oe_n(BUS_DATA_LINE_OE_N),
    .clk_out(BUS_CLOCK_HANDSHAKE_LINE),
    .sel_out(BUS_SELECT_LINE)
  );

  assign gaddr = 6'(r.loc + {2'h0, r.gidx});
  assign gbit = |mem[gaddr];

  //////////////////////////////////////////////////////////////////////////////
  // Next state: APB slave, then the transfer sequencer
  always_comb begin
    n = r;
    mem_we = 1'b0;
    mem_idx = r.loc;
    mem_wd = 32'h0;
    go_fire = 1'b0;
    acc = PSEL & PENABLE;
    in_mem = (PADDR[11:8] == `MEM_PAGE);
    // Done toggle crosses by three flops; stages two and three feed the compare
    n.ack1 = ack_tog;
    n.ack2 = r.ack1;
    n.ack3 = r.ack2;
    // Module computes state, duty and counts; the master widens them, then scales and offsets
    case (r.func)
      FN_STATE: raw = {31'h0, rx_word[0]};
      FN_SIGN: raw = {{16{rx_word[15]}}, rx_word[15:0]};
      default: raw = {16'h0, rx_word[15:0]};
    endcase
    prod = $signed(raw) * $signed(r.mult);
    scaled = prod[31:0] + r.offset;
    if (rx_word[16]) begin
      value = `ERR_VAL;
    end else if (r.mult == 16'h0) begin
      value = 32'h0;
    end else begin
      value = scaled;
    end

    // First access cycle: latch read data and error, answer next cycle
    n.pready = acc & ~r.pready;
    if (acc & ~r.pready) begin
      n.pslverr = 1'b0;
      n.prdata = 32'h0;
      if (in_mem) begin
        // Memory is the sequencer's while busy, so writes are refused then
        n.prdata = mem[PADDR[7:2]];
        n.pslverr = PWRITE & r.busy;
      end else begin
        case (PADDR)
          `CTRL_OFS: begin
            n.prdata = {12'h0, r.cfg_reps, r.cfg_chan, r.cfg_addr, r.func, r.op};
            n.pslverr = PWRITE & (r.busy | (PWDATA[`F_OP +: 2] == OP_RSVD));
          end
          `LOC_OFS: begin
            n.prdata = {26'h0, r.cfg_loc};
            n.pslverr = PWRITE & r.busy;
          end
          `MULT_OFS: begin
            n.prdata = {{16{r.mult[15]}}, r.mult};
            n.pslverr = PWRITE & r.busy;
          end
          `OFFS_OFS: begin
            n.prdata = r.offset;
            n.pslverr = PWRITE & r.busy;
          end
          `STAT_OFS: begin
            // Status is read only; writes are quietly dropped
            n.prdata = {16'h0, r.left, 5'h0, r.done, r.noresp, r.busy};
          end
          default: n.pslverr = 1'b1;
        endcase
      end
    end

    // Second access cycle: pready is high, so the write lands here
    wr_fire = acc & r.pready & PWRITE & ~r.pslverr;
    if (wr_fire) begin
      if (in_mem) begin
        mem_we = 1'b1;
        mem_idx = PADDR[7:2];
        mem_wd = PWDATA;
      end else begin
        case (PADDR)
          `CTRL_OFS: begin
            n.op = op_t'(PWDATA[`F_OP +: 2]);
            n.func = fn_t'(PWDATA[`F_FUNC +: 2]);
            n.cfg_addr = PWDATA[`F_ADDR +: 4];
            n.cfg_chan = PWDATA[`F_CHAN +: 4];
            n.cfg_reps = PWDATA[`F_REPS +: 8];
            go_fire = PWDATA[`F_GO];
          end
          `LOC_OFS: n.cfg_loc = PWDATA[5:0];
          `MULT_OFS: n.mult = PWDATA[15:0];
          `OFFS_OFS: n.offset = PWDATA;
          default: n.cfg_loc = r.cfg_loc;
        endcase
      end
    end

    // Start: load the walking address, channel and location
    if (go_fire) begin
      n.done = 1'b0;
      n.noresp = 1'b0;
      n.addr = PWDATA[`F_ADDR +: 4];
      n.chan = 3'(PWDATA[`F_CHAN +: 4] - 4'h1);
      n.loc = r.cfg_loc;
      n.sub = 2'h0;
      n.gidx = 4'h0;
      n.payload = 16'h0;
      // A signature needs a single repetition whatever was asked
      if (PWDATA[`F_OP +: 2] == OP_SWITCH && PWDATA[`F_FUNC +: 2] == FN_SIGN) begin
        n.left = 8'h1;
      end else begin
        n.left = PWDATA[`F_REPS +: 8];
      end
      if (n.left != 8'h0) begin
        n.busy = 1'b1;
        n.st = ST_PREP;
      end else begin
        n.done = 1'b1;
      end
    end

    // Sequencer
    case (r.st)
      ST_IDLE: begin
        n.payload = r.payload;
      end
      ST_PREP: begin
        case (r.op)
          OP_ANALOG: begin
            // Output index rides in the channel field, millivolts in payload
            n.chan = {1'b0, r.sub};
            n.payload = mem[r.loc][15:0];
            n.st = ST_SEND;
          end
          OP_PORTS: begin
            // One source location per cycle, sixteen in all
            n.payload[r.gidx] = gbit;
            n.gidx = r.gidx + 4'h1;
            if (r.gidx == `GATHER_LAST) begin
              n.st = ST_SEND;
            end
          end
          default: begin
            n.payload = 16'h0;
            n.st = ST_SEND;
          end
        endcase
      end
      ST_SEND: begin
        // Hand the frame to the link domain
        n.req = ~r.req;
        n.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (r.ack2 != r.ack3) begin
          n.st = ST_STORE;
        end
      end
      ST_STORE: begin
        if (rx_word[16]) begin
          n.noresp = 1'b1;
        end
        case (r.op)
          OP_ANALOG: begin
            n.loc = r.loc + 6'h1;
            n.sub = r.sub + 2'h1;
            if (r.sub == `AO_LAST) begin
              n.addr = r.addr + 4'h1;
            end
          end
          OP_PORTS: begin
            // Next repetition: next module, next sixteen locations
            n.loc = r.loc + `CD_STEP;
            n.addr = r.addr + 4'h1;
            n.gidx = 4'h0;
          end
          default: begin
            mem_we = 1'b1;
            mem_idx = r.loc;
            mem_wd = value;
            n.loc = r.loc + 6'h1;
            // Relies on modules set to rising consecutive addresses
            if (r.chan == `CHAN_LAST) begin
              n.chan = 3'h0;
              n.addr = r.addr + 4'h1;
            end else begin
              n.chan = r.chan + 3'h1;
            end
          end
        endcase
        n.left = r.left - 8'h1;
        if (r.left == 8'h1) begin
          n.busy = 1'b0;
          n.done = 1'b1;
          n.st = ST_IDLE;
        end else begin
          n.st = ST_PREP;
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; multiplier resets to zero so unset scaling gives zero
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
      r.mult <= `MULT_RST;
      r.offset <= `OFFS_RST;
    end else begin
      r <= n;
    end
  end

  // Location memory, no reset: software fills it before use
  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wd;
    end
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  start_chan_a: assert property (go_fire |=>
      r.chan == 3'($past(PWDATA[`F_CHAN +: 4]) - 4'h1))
    else $error("start channel not loaded as given minus one");
  sign_reps_a: assert property ((go_fire && PWDATA[`F_OP +: 2] == OP_SWITCH
      && PWDATA[`F_FUNC +: 2] == FN_SIGN) |=> r.left == 8'h1)
    else $error("signature read not limited to one repetition");
  chan_wrap_a: assert property ((r.st == ST_STORE && r.op == OP_SWITCH
      && r.chan == `CHAN_LAST) |=> r.chan == 3'h0 && r.addr == 4'($past(r.addr) + 4'h1))
    else $error("channel eight did not step to next module");
  dest_step_a: assert property ((r.st == ST_STORE && r.op == OP_SWITCH)
      |=> r.loc == 6'($past(r.loc) + 6'h1))
    else $error("destination did not advance by one");
  zero_mult_a: assert property ((r.st == ST_STORE && r.op == OP_SWITCH
      && !rx_word[16] && r.mult == 16'h0) |-> mem_we && mem_wd == 32'h0)
    else $error("reading not zero without multiplier");
  no_reply_a: assert property ((r.st == ST_STORE && r.op == OP_SWITCH
      && rx_word[16]) |-> mem_we && mem_wd == `ERR_VAL ##1 r.noresp)
    else $error("missing module did not give error value");
  analog_step_a: assert property ((r.st == ST_STORE && r.op == OP_ANALOG
      && r.sub == `AO_LAST) |=> r.addr == 4'($past(r.addr) + 4'h1) && r.sub == 2'h0)
    else $error("analog module not advanced after four values");
  ports_step_a: assert property ((r.st == ST_STORE && r.op == OP_PORTS)
      |=> r.loc == 6'($past(r.loc) + `CD_STEP) && r.addr == 4'($past(r.addr) + 4'h1))
    else $error("expander repetition did not move sixteen locations");
  port_state_a: assert property ((r.st == ST_PREP && r.op == OP_PORTS)
      |=> r.payload[$past(r.gidx)] == $past(gbit))
    else $error("port state does not follow source value");
  send_wait_a: assert property ((r.st == ST_SEND) |=> r.req != $past(r.req)
      && r.st == ST_WAIT)
    else $error("frame request not toggled on send");
endmodule

// ### testbench/periph_model.sv
// Behavioural peripheral module answering frames on the three-wire bus
`timescale 1ns/10ps
package periph_pkg;
  localparam logic [3:0] ABSENT = 4'hb;  // No module is fitted at this address
  // Data word that a module returns for address, function and channel
  function automatic logic [15:0] reply(input logic [3:0] a, input logic [1:0] f,
    input logic [2:0] c);
    case (f)
      2'h0: return {15'h0, c[0] ^ a[0]};
      2'h1: return {13'h0, c} * 16'h000a + {12'h0, a};
      2'h2: return {1'b1, 3'h0, a, 5'h0, c};
      default: return 16'hff80;
    endcase
  endfunction
endpackage

module periph_model import periph_pkg::*; (
  input wire logic sel,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic drive,
  output logic [26:0] frame
);
  logic [5:0] n;  // Clock rises seen in this frame
  logic [16:0] ans;  // Presence bit, then data
  initial begin
    n = 6'h0;
    drive = 1'b0;
    dout = 1'b1;
  end
  // Command bits taken on each clock rise, first bit is the MSB
  always @(posedge sclk) begin
    if (sel) begin
      if (n < 6'h1b) frame <= {frame[25:0], din};
      n <= n + 6'h1;
    end
  end
  // Reply launched after each clock fall; an empty address stays silent
  always @(negedge sclk) begin
    if (sel && n >= 6'h1b && n < 6'h2c && frame[26:23] != ABSENT) begin
      ans = {1'b0, reply(frame[26:23], frame[20:19], frame[18:16])};
      drive = 1'b1;
      dout = ans[6'h2b - n];
    end
  end
  // Line released at frame end, so the pull-up takes it over
  always @(negedge sel) begin
    drive = 1'b0;
    dout = ~dout;
    n = 6'h0;
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the peripheral bus master
`timescale 1ns/10ps
`include "spb_cfg.svh"
module tb_top import spb_pkg::*, periph_pkg::*;;
  logic CLK_SYS, RST_N, LINK_CLK, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, lvl;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r, st, offs;
  logic dat_o, oe_n, bclk, bsel, m_dout, m_drive;
  logic [26:0] m_frame;
  logic [15:0] mult;
  typedef struct packed {logic chk; logic err; logic [31:0] d;} note_t;
  typedef struct packed {logic [26:0] v; logic [26:0] m;} frm_t;
  note_t apb_q[$];  // Expected bus answers, oldest first
  frm_t frm_q[$];  // Expected frames, with a mask of fields that matter
  note_t ne;
  frm_t fe;
  logic [31:0] mem [64];  // Expected location memory
  int mismatches, checked;

  // Data wire: master, else module, else pull-up
  assign lvl = !oe_n ? dat_o : (m_drive ? m_dout : 1'b1);
  seq_bus_master seq_bus_master_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .LINK_CLK(LINK_CLK),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_DATA_LINE_I(lvl),
    .BUS_DATA_LINE_O(dat_o), .BUS_DATA_LINE_OE_N(oe_n), .BUS_CLOCK_HANDSHAKE_LINE(bclk),
    .BUS_SELECT_LINE(bsel));
  periph_model periph_model_inst (.sel(bsel), .sclk(bclk), .din(lvl), .dout(m_dout),
    .drive(m_drive), .frame(m_frame));

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Clocks: link clock offset so the two never line up
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    LINK_CLK = 1'b0;
    #7;
    forever #15 LINK_CLK = ~LINK_CLK;
  end

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic finish_test();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One APB transfer; held until PREADY is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input note_t n, output logic [31:0] q);
    apb_q.push_back(n);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1) @(posedge CLK_SYS);
    q = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d, '{1'b0, e, 32'h0}, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, '{1'b1, 1'b0, e}, r);
  endtask
  task automatic setk(input logic [15:0] m, input logic [31:0] o);
    mult = m;
    offs = o;
    wr(`MULT_OFS, {16'h0, m}, 1'b0);
    wr(`OFFS_OFS, o, 1'b0);
  endtask

  // Start one operation, note its frames and results, wait, read back status, multiplier and memory
  task automatic run(input op_t op, input fn_t fn, input logic [3:0] a, input logic [3:0] ch,
    input logic [7:0] reps, input logic [5:0] loc);
    logic [2:0] c;
    logic [5:0] l;
    logic [15:0] p;
    logic [31:0] raw;
    logic nr;
    int n;
    c = ch[2:0] - 3'h1;
    l = loc;
    nr = 1'b0;
    n = (op == OP_SWITCH && fn == FN_SIGN) ? 1 : int'(reps);
    wr(`LOC_OFS, {26'h0, loc}, 1'b0);
    wr(`CTRL_OFS, {1'b1, 11'h0, reps, ch, a, fn, op}, 1'b0);
    for (int i = 0; i < n; i++) begin
      p = (op == OP_ANALOG) ? mem[l][15:0] : 16'h0;
      if (op == OP_PORTS) for (int k = 0; k < 16; k++) p[k] = (mem[6'(l + k)] != 0);
      frm_q.push_back('{{a, op, fn, (op == OP_ANALOG) ? 3'(i % 4) : c, p},
        (op == OP_PORTS) ? 27'h7f8ffff : 27'h7ffffff});
      p = reply(a, fn, c);
      raw = fn == FN_SIGN ? {{16{p[15]}}, p} : fn == FN_STATE ? {31'h0, p[0]} : {16'h0, p};
      nr |= (op == OP_SWITCH && a == ABSENT);
      if (op == OP_SWITCH) mem[l] = (a == ABSENT) ? `ERR_VAL : (mult == 16'h0) ? 32'h0 :
        raw * {{16{mult[15]}}, mult} + offs;
      l = l + ((op == OP_PORTS) ? 6'h10 : 6'h1);
      if (op == OP_PORTS || (op == OP_ANALOG && i % 4 == 3) || (op == OP_SWITCH && c == 3'h7))
        a = a + 4'h1;
      if (op == OP_SWITCH) c = c + 3'h1;
    end
    // A write while the run is busy is refused and leaves the multiplier alone
    wr(`MULT_OFS, 32'h5, 1'b1);
    st = 32'h0;
    for (int q = 0; q < 3000 && st[2] !== 1'b1; q++)
      apb(1'b0, `STAT_OFS, 32'h0, '{1'b0, 1'b0, 32'h0}, st);
    // A run that never reports done is a failure; stop here rather than drift on
    if (st[2] !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    rd(`STAT_OFS, {29'h0, 1'b1, nr, 1'b0});
    rd(`MULT_OFS, {{16{mult[15]}}, mult});
    for (int j = 0; j < 64; j++) rd({`MEM_PAGE, 6'(j), 2'b00}, mem[j]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Each finished transfer against the oldest note
  always @(posedge CLK_SYS) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && apb_q.size() > 0) begin
      ne = apb_q.pop_front();
      cmp({31'h0, ne.err}, {31'h0, PSLVERR});
      if (ne.chk) cmp(ne.d, PRDATA);
    end
  end
  // Each frame end against the oldest expected frame; reset glitches ignored
  always @(negedge bsel) begin
    if (RST_N === 1'b1) begin
      if (frm_q.size() > 0) begin
        fe = frm_q.pop_front();
      end else begin
        // An unexpected frame must always count as a mismatch
        fe.v = ~m_frame;
        fe.m = 27'h7ffffff;
      end
      cmp({5'h0, fe.v & fe.m}, {5'h0, m_frame & fe.m});
    end
  end

  // Hang guard, well past the longest expected run
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end

  // Main sequence
  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    mismatches = 0;
    checked = 0;
    void'($urandom(32'h99020ab3));
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(`MULT_OFS, 32'h0);
    rd(`OFFS_OFS, 32'h0);
    apb(1'b0, 12'h020, 32'h0, '{1'b0, 1'b1, 32'h0}, r);
    wr(`CTRL_OFS, {1'b1, 29'h0, 2'b11}, 1'b1);
    for (int j = 0; j < 64; j++) begin
      mem[j] = ($urandom % 3 == 0) ? 32'h0 : $urandom;
      wr({`MEM_PAGE, 6'(j), 2'b00}, mem[j], 1'b0);
    end
    setk(16'($urandom), $urandom);
    for (int f = 0; f < 4; f++) run(OP_SWITCH, fn_t'(f), 4'h6, 4'h7, 8'hc, 6'(8 * f));
    setk(16'h0, 32'h7);
    run(OP_SWITCH, FN_DUTY, 4'h2, 4'h1, 8'h3, 6'h20);
    setk(16'hfffd, 32'h0);
    run(OP_SWITCH, FN_COUNT, 4'ha, 4'h8, 8'h3, 6'h28);
    run(OP_ANALOG, FN_STATE, 4'hf, 4'h1, 8'h6, 6'h3c);
    run(OP_PORTS, FN_STATE, 4'hf, 4'h1, 8'h2, 6'h28);
    cmp(32'h0, 32'(frm_q.size()));
    finish_test();
  end
endmodule
